// file: shared/idr_pkg.sv
// Constants and types shared by the identify responder files
package idr_pkg;

	// ****************
	// Task file
	// ****************
	localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
	localparam logic [2:0] ADDR_COMMAND = 3'h7;
	localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
	localparam logic [7:0] DH_ONES_MASK = 8'hA0;
	localparam int DH_DEV_BIT = 4;

	// ****************
	// Status and error fields
	// ****************
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_READY_BIT = 6;
	localparam int ST_DEVICE_FAULT_BIT = 5;
	localparam int ST_SEEK_COMPLETE_BIT = 4;
	localparam int ST_DATA_REQ_BIT = 3;
	localparam int ST_CORRECTED_DATA_BIT = 2;
	localparam int ST_ERROR_BIT = 0;
	localparam int ER_ABORT_ERROR_BIT = 2;
	localparam logic [7:0] STATUS_RESET = 8'h50;
	localparam logic [7:0] ERROR_RESET = 8'h00;
	localparam logic [7:0] ERROR_ABORT_ONLY = 8'h04;

	// ****************
	// Identify data
	// ****************
	localparam logic [8:0] SECTOR_WORDS = 9'h100;
	localparam logic [15:0] W_CONFIG_COMPLETE = 16'h045A;
	localparam logic [15:0] W_SPIN_NEED_SETF = 16'h738C;
	localparam logic [15:0] W_SPIN_NO_SETF = 16'hC837;
	localparam logic [15:0] W_SECTORS_PER_TRACK = 16'h003F;
	localparam logic [15:0] W_CTRL_TYPE = 16'h0003;
	localparam logic [15:0] W_RESERVED_22 = 16'h0038;
	localparam logic [7:0] W_MULTI_UPPER = 8'h80;
	localparam logic [15:0] W_SECURE_BASE = 16'h4000;
	localparam logic [31:0] BUF_64MB_UNITS = 32'h0002_0000;
	localparam logic [8:0] W_SERIAL_FIRST = 9'h00A;
	localparam logic [8:0] W_FW_FIRST = 9'h017;
	localparam logic [8:0] W_MODEL_FIRST = 9'h01B;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_XFER = 3'b100
	} idr_state_t;

endpackage

// file: shared/idr_if.sv
// Valid/ready word channel between the word generator and the buffer
`timescale 1ns/1ns
`default_nettype none
interface idr_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: core/idr_buf.sv
// Two-entry buffer on the identify data path
`timescale 1ns/1ns
`default_nettype none
module idr_buf #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	idr_if.snk in_s,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import idr_pkg::*;

	logic [W-1:0] mem_q [2];
	logic [W-1:0] mem_d [2];
	logic rd_q, rd_d, wr_q, wr_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;

	// Ready depends only on fill level, never on out_ready
	assign in_s.ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		rd_d = rd_q;
		wr_d = wr_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_s.data;
			wr_d = ~wr_q;
		end
		if (pop) begin
			rd_d = ~rd_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
		end
	end

endmodule // idr_buf
`default_nettype wire

// file: core/idr_top.sv
// Identify command responder: task file decode, identify word generator, status
`timescale 1ns/1ns
`default_nettype none
module idr_top #(
	parameter logic DEV_SELECT = 1'b0,
	parameter logic [15:0] CYLINDERS = 16'h3FFF,
	parameter logic [7:0] HEADS = 8'h10,
	parameter logic [31:0] BUF_SECTORS = 32'h0002_0000,
	parameter logic [7:0] MULTI_MAX = 8'h10,
	parameter logic SPINUP_NEEDS_SETF = 1'b0,
	parameter logic SECURE_SUPPORTED = 1'b0,
	parameter logic [159:0] SERIAL_TEXT = '0,
	parameter logic [63:0] FW_TEXT = 64'h3130_3030_3030_3030,
	parameter logic [319:0] MODEL_TEXT = {20{16'h2020}}
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic host_wr,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic data_valid,
	input wire logic data_ready,
	output logic [15:0] data_word,
	output logic [7:0] command_status_flags,
	output logic [7:0] command_error_flags
);
	import idr_pkg::*;

	// ****************
	// Reset release
	// ****************
	logic rst_meta_q, rst_n_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************
	// Identify word table
	// ****************
	function automatic logic [15:0] text_word(input logic [319:0] txt, input int n, input int idx);
		logic [319:0] sh;
		sh = txt << (16 * idx);
		return sh[319 -: 16] & {16{idx < n}};
	endfunction

	function automatic logic [15:0] word_at(input logic [8:0] idx);
		logic [15:0] w;
		w = 16'h0000;
		case (idx) inside
			9'h000: w = W_CONFIG_COMPLETE;
			9'h001: w = CYLINDERS;
			9'h002: w = SPINUP_NEEDS_SETF ? W_SPIN_NEED_SETF : W_SPIN_NO_SETF;
			9'h003: w = {8'h00, HEADS};
			9'h006: w = W_SECTORS_PER_TRACK;
			9'h004, 9'h005, 9'h007, 9'h008, 9'h009: w = 16'h0000;
			[9'h00A:9'h013]: w = text_word({SERIAL_TEXT, 160'h0}, 10, 32'(idx - W_SERIAL_FIRST));
			9'h014: w = W_CTRL_TYPE;
			9'h015: w = (BUF_SECTORS == BUF_64MB_UNITS) ? 16'h0000 : BUF_SECTORS[15:0];
			9'h016: w = W_RESERVED_22;
			[9'h017:9'h01A]: w = text_word({FW_TEXT, 256'h0}, 4, 32'(idx - W_FW_FIRST));
			[9'h01B:9'h02E]: w = text_word(MODEL_TEXT, 20, 32'(idx - W_MODEL_FIRST));
			9'h02F: w = {W_MULTI_UPPER, MULTI_MAX};
			9'h030: w = W_SECURE_BASE | {15'h0000, SECURE_SUPPORTED};
			// Words beyond 48, up to 255, are still produced by this block and read zero
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// ****************
	// Command decode and sequencing
	// ****************
	idr_state_t state_q, state_d;
	logic [8:0] word_q, word_d;
	logic [7:0] devhead_q, devhead_d;
	logic [7:0] status_q, status_d;
	logic [7:0] error_q, error_d;
	logic cmd_wr, selected, gen_push;

	idr_if #(.W(16)) gen_s ();

	assign cmd_wr = host_wr && (host_addr == ADDR_COMMAND);
	// Drive is addressed only when the host kept the fixed ones and picked our number
	assign selected = ((devhead_q & DH_ONES_MASK) == DH_ONES_MASK) && (devhead_q[DH_DEV_BIT] == DEV_SELECT);
	assign gen_s.valid = (state_q == ST_XFER) && (word_q != SECTOR_WORDS);
	assign gen_s.data = word_at(word_q);
	assign gen_push = gen_s.valid && gen_s.ready;

	always_comb begin
		state_d = state_q;
		word_d = word_q;
		devhead_d = devhead_q;
		status_d = status_q;
		error_d = error_q;
		if (host_wr && host_addr == ADDR_DEVHEAD && state_q == ST_IDLE) begin
			devhead_d = host_wdata;
		end
		case (state_q)
			ST_IDLE: begin
				// Writes while a command runs are dropped
				if (cmd_wr && selected) begin
					error_d = ERROR_RESET;
					status_d = 8'h00;
					status_d[ST_BUSY_BIT] = 1'b1;
					if (host_wdata == CMD_IDENTIFY) begin
						state_d = ST_BUSY;
						word_d = 9'h000;
					end else begin
						state_d = ST_BUSY;
						word_d = SECTOR_WORDS;
						error_d = ERROR_ABORT_ONLY;
					end
				end
			end
			ST_BUSY: begin
				status_d[ST_BUSY_BIT] = 1'b0;
				status_d[ST_READY_BIT] = 1'b1;
				status_d[ST_SEEK_COMPLETE_BIT] = 1'b1;
				if (error_q[ER_ABORT_ERROR_BIT]) begin
					state_d = ST_IDLE;
					status_d[ST_ERROR_BIT] = 1'b1;
				end else begin
					state_d = ST_XFER;
					status_d[ST_DATA_REQ_BIT] = 1'b1;
				end
			end
			ST_XFER: begin
				if (gen_push) begin
					word_d = word_q + 9'h001;
				end
				// Done only once the host has drained the last buffered word
				if (word_q == SECTOR_WORDS && !data_valid) begin
					state_d = ST_IDLE;
					status_d = STATUS_RESET;
				end
			end
			default: begin
				state_d = ST_IDLE;
				status_d = STATUS_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_IDLE;
			word_q <= 9'h000;
			devhead_q <= 8'h00;
			status_q <= STATUS_RESET;
			error_q <= ERROR_RESET;
		end else begin
			state_q <= state_d;
			word_q <= word_d;
			devhead_q <= devhead_d;
			status_q <= status_d;
			error_q <= error_d;
		end
	end

	assign command_status_flags = status_q;
	assign command_error_flags = error_q;

	// ****************
	// Data path buffer
	// ****************
	idr_buf #(.W(16)) u_buf (
		.clk(clk),
		.rst_n(rst_n_q),
		.in_s(gen_s),
		.out_valid(data_valid),
		.out_ready(data_ready),
		.out_data(data_word)
	);

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	logic [9:0] pushed_q;
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pushed_q <= 10'h000;
		end else if (state_q == ST_IDLE) begin
			pushed_q <= 10'h000;
		end else if (gen_push) begin
			pushed_q <= pushed_q + 10'h001;
		end
	end

	// ****************
	// Sequencing checks
	// ****************
	identify_decode_a: assert property ((state_q == ST_IDLE) && cmd_wr && selected
		&& host_wdata == CMD_IDENTIFY |=> state_q == ST_BUSY ##1 state_q == ST_XFER && word_q == 9'h000)
		else $error("identify code not decoded");
	unselected_drop_a: assert property ((state_q == ST_IDLE) && cmd_wr && !selected
		|=> state_q == ST_IDLE && $stable(status_q) && $stable(error_q))
		else $error("unselected command acted on");
	busy_drop_a: assert property ((state_q != ST_IDLE) && cmd_wr |=> state_q != ST_BUSY)
		else $error("command taken while busy");
	sector_count_a: assert property ((state_q == ST_XFER) && state_d == ST_IDLE |-> pushed_q == 10'h100)
		else $error("sector not 256 words");
	push_limit_a: assert property (pushed_q <= 10'h100)
		else $error("more than one sector pushed");
	drq_cover_a: assert property (data_valid |-> status_q[ST_DATA_REQ_BIT] && !status_q[ST_BUSY_BIT])
		else $error("word offered without data request");
	// Stall must never drop or change the offered word
	stall_hold_a: assert property (data_valid && !data_ready |=> data_valid && $stable(data_word))
		else $error("stalled word lost");

	// ****************
	// Identify word checks
	// ****************
	// Text expectations sliced directly, not through the table function
	word_zero_a: assert property (gen_s.valid && word_q == 9'h000
		|-> gen_s.data == 16'h045A && !gen_s.data[2])
		else $error("word 0 wrong");
	cyl_word_a: assert property (gen_s.valid && word_q == 9'h001
		|-> gen_s.data == CYLINDERS)
		else $error("word 1 wrong");
	spin_word_a: assert property (gen_s.valid && word_q == 9'h002
		|-> gen_s.data == (SPINUP_NEEDS_SETF ? 16'h738C : 16'hC837))
		else $error("word 2 wrong");
	head_word_a: assert property (gen_s.valid && word_q == 9'h003
		|-> gen_s.data[15:8] == 8'h00 && gen_s.data[7:0] == HEADS)
		else $error("word 3 wrong");
	geom_words_a: assert property (gen_s.valid && word_q == 9'h006
		|-> gen_s.data == 16'h003F)
		else $error("word 6 wrong");
	zero_words_a: assert property (gen_s.valid && (word_q inside {9'h004, 9'h005, 9'h007, 9'h008, 9'h009})
		|-> gen_s.data == 16'h0000)
		else $error("reserved word not zero");
	serial_text_a: assert property (gen_s.valid && (word_q inside {[9'h00A:9'h013]})
		|-> gen_s.data == SERIAL_TEXT[159 - 16 * int'(word_q - 9'h00A) -: 16])
		else $error("serial word wrong");
	ctrl_type_a: assert property (gen_s.valid && word_q == 9'h014
		|-> gen_s.data == 16'h0003)
		else $error("word 20 wrong");
	buf_size_a: assert property (gen_s.valid && word_q == 9'h015
		|-> gen_s.data == ((BUF_SECTORS == 32'h0002_0000) ? 16'h0000 : BUF_SECTORS[15:0]))
		else $error("word 21 wrong");
	fw_text_a: assert property (gen_s.valid && (word_q inside {[9'h017:9'h01A]})
		|-> gen_s.data == FW_TEXT[63 - 16 * int'(word_q - 9'h017) -: 16])
		else $error("firmware word wrong");
	model_text_a: assert property (gen_s.valid && (word_q inside {[9'h01B:9'h02E]})
		|-> gen_s.data == MODEL_TEXT[319 - 16 * int'(word_q - 9'h01B) -: 16])
		else $error("model word wrong");
	multi_word_a: assert property (gen_s.valid && word_q == 9'h02F
		|-> gen_s.data == {8'h80, MULTI_MAX})
		else $error("word 47 wrong");
	secure_word_a: assert property (gen_s.valid && word_q == 9'h030
		|-> gen_s.data[15:1] == 15'h2000 && gen_s.data[0] == SECURE_SUPPORTED)
		else $error("word 48 wrong");

	// ****************
	// Status and error checks
	// ****************
	cmd_clear_a: assert property ((state_q == ST_IDLE) && cmd_wr && selected
		&& host_wdata == CMD_IDENTIFY |=> status_q == 8'h80 && error_q == 8'h00)
		else $error("busy entry status wrong");
	busy_short_a: assert property (state_q == ST_BUSY |-> status_q[ST_BUSY_BIT] ##1 !status_q[ST_BUSY_BIT])
		else $error("busy not cleared");
	xfer_end_a: assert property ((state_q == ST_XFER) && word_q == SECTOR_WORDS && !data_valid
		|=> state_q == ST_IDLE && status_q == 8'h50 && error_q == 8'h00)
		else $error("completion not reported");
	done_status_a: assert property ($fell(status_q[ST_DATA_REQ_BIT])
		|-> !status_q[ST_BUSY_BIT] && !status_q[ST_DEVICE_FAULT_BIT] && !status_q[ST_CORRECTED_DATA_BIT]
		&& error_q == 8'h00)
		else $error("completion status wrong");
	abort_only_a: assert property ((state_q == ST_IDLE) && cmd_wr && selected
		&& host_wdata != CMD_IDENTIFY |=> ##1 error_q == 8'h04 && status_q[ST_ERROR_BIT] && !data_valid)
		else $error("abort report wrong");
	err_pair_a: assert property (status_q[ST_ERROR_BIT] |-> error_q == 8'h04)
		else $error("error bit without abort code");

endmodule // idr_top
`default_nettype wire

// file: tb/idr_host_sink.sv
// Host-side sink for the identify word stream
`timescale 1ns/1ns
`default_nettype none
module idr_host_sink (
	input wire logic clk,
	input wire logic run,
	input wire logic data_valid,
	input wire logic [15:0] data_word,
	output logic data_ready
);
	logic [15:0] words [0:511];
	int count;
	int phase;
	initial begin
		data_ready = 1'b0;
		count = 0;
		phase = 0;
	end
	// Refuse one cycle in three, so the buffer always sees back pressure
	always @(negedge clk) begin
		phase <= (phase + 1) % 3;
		data_ready <= run && (phase != 0);
	end
	always @(posedge clk) begin
		if (data_valid && data_ready && count < 512) begin
			words[count] <= data_word;
			count <= count + 1;
		end
	end
endmodule // idr_host_sink
`default_nettype wire

// file: tb/idr_top_bench.sv
// Self-checking bench for the identify responder
`timescale 1ns/1ns
`default_nettype none
module idr_top_bench;
	import idr_pkg::*;
	// Every text word differs, so a swapped or shifted word shows up
	localparam logic [159:0] SER = 160'h5331_5332_5333_5334_5335_5336_5337_5338_5339_5341;
	localparam logic [63:0] FW = 64'h3132_3334_3536_3738;
	localparam logic [319:0] MDL = {160'h4D30_4D31_4D32_4D33_4D34_4D35_4D36_4D37_4D38_4D39,
		160'h4E30_4E31_4E32_4E33_4E34_4E35_4E36_4E37_4E38_4E39};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic host_wr = 1'b0;
	logic [2:0] host_addr = 3'h0;
	logic [7:0] host_wdata = 8'h00;
	logic run = 1'b0;
	logic data_valid, data_ready;
	logic [15:0] data_word;
	logic [7:0] command_status_flags, command_error_flags;
	logic [7:0] bad [0:2] = '{8'hB0, 8'h20, 8'h80};
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;

	idr_top #(.CYLINDERS(16'h1234), .HEADS(8'h0C), .SERIAL_TEXT(SER), .FW_TEXT(FW), .MODEL_TEXT(MDL)) uut (
		.clk(clk), .reset_n(reset_n), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata), .data_valid(data_valid), .data_ready(data_ready),
		.data_word(data_word), .command_status_flags(command_status_flags),
		.command_error_flags(command_error_flags));
	idr_host_sink sink (.clk(clk), .run(run), .data_valid(data_valid), .data_word(data_word),
		.data_ready(data_ready));

	always #25 clk = ~clk;

	// ****************
	// Tasks
	// ****************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		host_wr = 1'b1;
		host_addr = a;
		host_wdata = d;
		@(negedge clk);
		host_wr = 1'b0;
	endtask

	function automatic logic [15:0] exp_word(input int i);
		case (i)
			0: return 16'h045A;
			1: return 16'h1234;
			2: return 16'hC837;
			3: return 16'h000C;
			6: return 16'h003F;
			20: return 16'h0003;
			21: return 16'h0000;
			22: return 16'h0038;
			47: return 16'h8010;
			48: return 16'h4000;
			default: begin
				if (i >= 10 && i <= 19) return SER[159 - 16 * (i - 10) -: 16];
				if (i >= 23 && i <= 26) return FW[63 - 16 * (i - 23) -: 16];
				if (i >= 27 && i <= 46) return MDL[319 - 16 * (i - 27) -: 16];
				return 16'h0000;
			end
		endcase
	endfunction

	// Hang guard, far above the roughly 850 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			print_verdict;
		end
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		chk("status", command_status_flags, 8'h50);
		chk("error", command_error_flags, 8'h00);
		chk("valid", data_valid, 1'b0);
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_DEVHEAD, bad[k]);
			wr(ADDR_COMMAND, CMD_IDENTIFY);
			repeat (3) @(negedge clk);
			chk("ignored", command_status_flags, 8'h50);
		end
		wr(ADDR_DEVHEAD, 8'hA0);
		wr(ADDR_COMMAND, 8'h50);
		chk("busy", command_status_flags, 8'h80);
		@(negedge clk);
		chk("abort status", command_status_flags, 8'h51);
		chk("abort error", command_error_flags, 8'h04);
		wr(ADDR_COMMAND, CMD_IDENTIFY);
		chk("busy", command_status_flags, 8'h80);
		@(negedge clk);
		chk("drq status", command_status_flags, 8'h58);
		// Both writes land mid-transfer and must be dropped
		wr(ADDR_DEVHEAD, 8'hB0);
		wr(ADDR_COMMAND, 8'h50);
		chk("no restart", command_status_flags, 8'h58);
		chk("no abort", command_error_flags, 8'h00);
		// Host holds off long enough to fill the buffer
		repeat (20) @(negedge clk);
		chk("held", data_word, 16'h045A);
		run = 1'b1;
		for (int n = 0; n < 2000 && command_status_flags !== 8'h50; n++) @(negedge clk);
		repeat (10) @(negedge clk);
		chk("count", sink.count[15:0], 16'h0100);
		chk("done error", command_error_flags, 8'h00);
		chk("valid", data_valid, 1'b0);
		// Second identify relies on the selection kept from before the dropped write
		wr(ADDR_COMMAND, CMD_IDENTIFY);
		chk("second busy", command_status_flags, 8'h80);
		for (int n = 0; n < 2000 && command_status_flags !== 8'h50; n++) @(negedge clk);
		repeat (10) @(negedge clk);
		chk("second count", sink.count[15:0], 16'h0200);
		chk("second error", command_error_flags, 8'h00);
		for (int i = 0; i < 512; i++) chk($sformatf("word %0d", i), sink.words[i], exp_word(i % 256));
		print_verdict;
	end
endmodule // idr_top_bench
`default_nettype wire
